// *** hdl/tdr_pkg.sv ***
// Constants shared by the temperature readout and override register block.
`default_nettype none
package tdr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_TEMP_HI = 8'h00;
    localparam logic [7:0] A_TEMP_LO = 8'h01;
    localparam logic [7:0] A_CH0_HI = 8'h02;
    localparam logic [7:0] A_CH0_LO = 8'h03;
    localparam logic [7:0] A_CH1_HI = 8'h04;
    localparam logic [7:0] A_CH1_LO = 8'h05;
    localparam logic [7:0] A_STATUS = 8'h07;
    localparam logic [7:0] A_OVR_SEL = 8'h08;
    localparam logic [7:0] A_GATE = 8'h11;
    // Forced temperature, forced code 0, forced code 1: high byte, low byte follows.
    localparam int OVR_N = 3;
    localparam logic [7:0] A_OVR_HI [OVR_N] = '{8'h09, 8'h0b, 8'h0d};
    localparam logic [7:0] A_OVR_LO [OVR_N] = '{8'h0a, 8'h0c, 8'h0e};
    localparam int OVR_TEMP = 0;
    localparam int OVR_CH0 = 1;
    localparam int OVR_CH1 = 2;
    // ------------------------------------------------------------
    // Fields and values
    // ------------------------------------------------------------
    localparam int SEL_TEMP_BIT = 0;
    localparam int SEL_CODE_BIT = 1;
    localparam logic [7:0] PWD_FIRST = 8'hcd;
    localparam logic [7:0] PWD_PRIV = 8'hf0;
    localparam logic [7:0] PWD_MID = 8'hef;
    localparam logic [1:0] LVL_OPEN = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_PRIV = 2'h3;
    localparam logic [7:0] STATUS_RST = 8'h01;
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [11:0] WORD_RST = 12'h000;
    localparam logic [7:0] RD_RST = 8'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 100000;
    localparam int SAMPLE_MS = 25;
    localparam int SAMPLE_CYC = SAMPLE_MS * CLK_KHZ;
    localparam int CNT_W = 22;
endpackage
`default_nettype wire

// *** hdl/tdr_readout.sv ***
// Temperature sample and dual DAC code readout with host override registers.
`default_nettype none
module tdr_readout #(
    parameter int unsigned SAMPLE_CYC = tdr_pkg::SAMPLE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    output logic o_sample_req,
    input wire logic i_sample_stb,
    input wire logic [11:0] i_sample,
    input wire logic i_sensor_ready,
    input wire logic i_lut_stb,
    input wire logic [11:0] i_lut_code0,
    input wire logic [11:0] i_lut_code1,
    output logic [11:0] o_lut_index,
    output logic [11:0] o_dac0_code,
    output logic [11:0] o_dac1_code
);
    import tdr_pkg::*;

    function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
        return stb && (a == off);
    endfunction

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire logic rd_th = hit(i_rd_stb, i_addr, A_TEMP_HI);
    wire logic rd_tl = hit(i_rd_stb, i_addr, A_TEMP_LO);
    wire logic rd_c0h = hit(i_rd_stb, i_addr, A_CH0_HI);
    wire logic rd_c0l = hit(i_rd_stb, i_addr, A_CH0_LO);
    wire logic rd_c1h = hit(i_rd_stb, i_addr, A_CH1_HI);
    wire logic rd_c1l = hit(i_rd_stb, i_addr, A_CH1_LO);
    wire logic wr_sel = hit(i_wr_stb, i_addr, A_OVR_SEL);
    wire logic wr_gate = hit(i_wr_stb, i_addr, A_GATE);

    // ------------------------------------------------------------
    // Sample request timer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] tick_ff;
    wire logic tick_end = (tick_ff == CNT_W'(SAMPLE_CYC - 1));
    wire logic [CNT_W-1:0] nxt_tick = tick_end ? '0 : tick_ff + 1'b1;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_ff <= '0;
            o_sample_req <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
            o_sample_req <= tick_end;
        end
    end

    // ------------------------------------------------------------
    // Live values, snapshots and sensor status
    // ------------------------------------------------------------
    logic [11:0] live_temp_ff, live0_ff, live1_ff;
    logic [11:0] snap_temp_ff, snap0_ff, snap1_ff;
    logic pend_t_ff, pend0_ff, pend1_ff;
    logic [7:0] status_ff;

    wire logic [11:0] nxt_live_temp = i_sample_stb ? i_sample : live_temp_ff;
    wire logic [11:0] nxt_live0 = i_lut_stb ? i_lut_code0 : live0_ff;
    wire logic [11:0] nxt_live1 = i_lut_stb ? i_lut_code1 : live1_ff;
    // A temperature high read freezes all three words; a code high read
    // while its own pair is not pending freezes that pair only.
    wire logic snap0_take = rd_th || (rd_c0h && !pend0_ff);
    wire logic snap1_take = rd_th || (rd_c1h && !pend1_ff);
    wire logic [11:0] nxt_snap_temp = rd_th ? live_temp_ff : snap_temp_ff;
    wire logic [11:0] nxt_snap0 = snap0_take ? live0_ff : snap0_ff;
    wire logic [11:0] nxt_snap1 = snap1_take ? live1_ff : snap1_ff;
    wire logic nxt_pend_t = rd_th ? 1'b1 : (rd_tl ? 1'b0 : pend_t_ff);
    wire logic nxt_pend0 = (rd_th || rd_c0h) ? 1'b1 : (rd_c0l ? 1'b0 : pend0_ff);
    wire logic nxt_pend1 = (rd_th || rd_c1h) ? 1'b1 : (rd_c1l ? 1'b0 : pend1_ff);
    wire logic [7:0] nxt_status = (i_sample_stb && i_sensor_ready) ? STATUS_OK : status_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            live_temp_ff <= WORD_RST;
            live0_ff <= WORD_RST;
            live1_ff <= WORD_RST;
            snap_temp_ff <= WORD_RST;
            snap0_ff <= WORD_RST;
            snap1_ff <= WORD_RST;
            pend_t_ff <= 1'b0;
            pend0_ff <= 1'b0;
            pend1_ff <= 1'b0;
            status_ff <= STATUS_RST;
        end else begin
            live_temp_ff <= nxt_live_temp;
            live0_ff <= nxt_live0;
            live1_ff <= nxt_live1;
            snap_temp_ff <= nxt_snap_temp;
            snap0_ff <= nxt_snap0;
            snap1_ff <= nxt_snap1;
            pend_t_ff <= nxt_pend_t;
            pend0_ff <= nxt_pend0;
            pend1_ff <= nxt_pend1;
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------
    // Access gate and override select
    // ------------------------------------------------------------
    logic armed_ff;
    logic [1:0] level_ff;
    logic [1:0] sel_ff;
    wire logic priv = (level_ff == LVL_PRIV);
    wire logic [1:0] nxt_level = (wr_gate && armed_ff && i_wdata == PWD_PRIV) ? LVL_PRIV :
        (wr_gate && armed_ff && i_wdata == PWD_MID) ? (level_ff | LVL_MID) : level_ff;
    wire logic nxt_armed = wr_gate ? (i_wdata == PWD_FIRST) : armed_ff;
    // Reserved select bits are never stored, so they cannot steer anything.
    wire logic [1:0] nxt_sel = (wr_sel && priv) ? i_wdata[1:0] : sel_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_ff <= 1'b0;
            level_ff <= LVL_OPEN;
            sel_ff <= SEL_RST;
        end else begin
            armed_ff <= nxt_armed;
            level_ff <= nxt_level;
            sel_ff <= nxt_sel;
        end
    end

    // ------------------------------------------------------------
    // Override data words
    // ------------------------------------------------------------
    logic [11:0] ovr_ff [OVR_N];
    logic [3:0] hold_hi_ff [OVR_N];

    for (genvar g = 0; g < OVR_N; g++) begin : g_ovr
        wire logic wr_hi = hit(i_wr_stb, i_addr, A_OVR_HI[g]) && priv;
        wire logic wr_lo = hit(i_wr_stb, i_addr, A_OVR_LO[g]) && priv;
        wire logic [3:0] nxt_hold_hi = wr_hi ? i_wdata[3:0] : hold_hi_ff[g];
        wire logic [11:0] nxt_ovr = wr_lo ? {hold_hi_ff[g], i_wdata} : ovr_ff[g];

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                hold_hi_ff[g] <= 4'h0;
                ovr_ff[g] <= WORD_RST;
            end else begin
                hold_hi_ff[g] <= nxt_hold_hi;
                ovr_ff[g] <= nxt_ovr;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire logic [11:0] tl_src = pend_t_ff ? snap_temp_ff : live_temp_ff;
    wire logic [11:0] c0_src = pend0_ff ? snap0_ff : live0_ff;
    wire logic [11:0] c1_src = pend1_ff ? snap1_ff : live1_ff;
    // Registers with no storage of their own, and unmapped ones, read as zero.
    wire logic [7:0] nxt_rdata =
        (i_addr == A_TEMP_HI) ? {4'h0, live_temp_ff[11:8]} :
        (i_addr == A_TEMP_LO) ? tl_src[7:0] :
        (i_addr == A_CH0_HI) ? {4'h0, c0_src[11:8]} :
        (i_addr == A_CH0_LO) ? c0_src[7:0] :
        (i_addr == A_CH1_HI) ? {4'h0, c1_src[11:8]} :
        (i_addr == A_CH1_LO) ? c1_src[7:0] :
        (i_addr == A_STATUS) ? status_ff :
        (i_addr == A_OVR_SEL) ? {6'h00, sel_ff} :
        (i_addr == A_OVR_HI[OVR_TEMP]) ? {4'h0, ovr_ff[OVR_TEMP][11:8]} :
        (i_addr == A_OVR_LO[OVR_TEMP]) ? ovr_ff[OVR_TEMP][7:0] :
        (i_addr == A_OVR_HI[OVR_CH0]) ? {4'h0, ovr_ff[OVR_CH0][11:8]} :
        (i_addr == A_OVR_LO[OVR_CH0]) ? ovr_ff[OVR_CH0][7:0] :
        (i_addr == A_OVR_HI[OVR_CH1]) ? {4'h0, ovr_ff[OVR_CH1][11:8]} :
        (i_addr == A_OVR_LO[OVR_CH1]) ? ovr_ff[OVR_CH1][7:0] :
        (i_addr == A_GATE) ? {6'h00, level_ff} : RD_RST;

    // ------------------------------------------------------------
    // Data path selection
    // ------------------------------------------------------------
    // Select value 0x03 is outside the host contract; both overrides then apply.
    wire logic [11:0] nxt_index = sel_ff[SEL_TEMP_BIT] ? ovr_ff[OVR_TEMP] : live_temp_ff;
    wire logic [11:0] nxt_dac0 = sel_ff[SEL_CODE_BIT] ? ovr_ff[OVR_CH0] : live0_ff;
    wire logic [11:0] nxt_dac1 = sel_ff[SEL_CODE_BIT] ? ovr_ff[OVR_CH1] : live1_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= RD_RST;
            o_rd_valid <= 1'b0;
            o_lut_index <= WORD_RST;
            o_dac0_code <= WORD_RST;
            o_dac1_code <= WORD_RST;
        end else begin
            o_rdata <= i_rd_stb ? nxt_rdata : o_rdata;
            o_rd_valid <= i_rd_stb;
            o_lut_index <= nxt_index;
            o_dac0_code <= nxt_dac0;
            o_dac1_code <= nxt_dac1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    logic [7:0] rd_addr_ff;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_addr_ff <= 8'h00;
        end else begin
            rd_addr_ff <= i_rd_stb ? i_addr : rd_addr_ff;
        end
    end

    sequence s_pwd;
        wr_gate && i_wdata == PWD_FIRST ##1 wr_gate && i_wdata == PWD_PRIV;
    endsequence

    sequence s_temp_pair;
        rd_th ##1 (!i_rd_stb && i_sample_stb) ##1 rd_tl;
    endsequence

    a_sample_gap: assert property (o_sample_req |=> !o_sample_req [*8])
        else $error("sample requests too close together");
    a_temp_hi_zero: assert property (o_rd_valid && rd_addr_ff == A_TEMP_HI
        |-> o_rdata[7:4] == 4'h0)
        else $error("temperature high upper bits not zero");
    a_code_hi_zero: assert property (o_rd_valid
        && (rd_addr_ff == A_CH0_HI || rd_addr_ff == A_CH1_HI) |-> o_rdata[7:4] == 4'h0)
        else $error("code high upper bits not zero");
    a_temp_pair_same: assert property (s_temp_pair |=> o_rdata == $past(snap_temp_ff[7:0], 2))
        else $error("temperature low not from the snapped sample");
    a_skip_low: assert property (rd_th ##1 (!i_rd_stb)[*1] ##1 rd_c0h
        |=> o_rdata == {4'h0, $past(snap0_ff[11:8], 2)})
        else $error("code 0 high not from snapshot");
    a_status_clear: assert property (i_sample_stb && i_sensor_ready
        |=> status_ff == STATUS_OK [*2])
        else $error("status not cleared by valid sample");
    a_code_mux: assert property (##1 o_dac0_code
        == ($past(sel_ff[SEL_CODE_BIT]) ? $past(ovr_ff[OVR_CH0]) : $past(live0_ff)))
        else $error("dac 0 source wrong");
    a_index_mux: assert property (sel_ff[SEL_TEMP_BIT] && $stable(ovr_ff[OVR_TEMP])
        |=> o_lut_index == $past(ovr_ff[OVR_TEMP]))
        else $error("lut index not forced temperature");
    a_hi_pending: assert property (hit(i_wr_stb, i_addr, A_OVR_HI[OVR_TEMP])
        |=> $stable(ovr_ff[OVR_TEMP]))
        else $error("high nibble applied before low byte");
    a_pwd_grant: assert property (s_pwd |=> priv)
        else $error("password did not raise level");
    a_sel_locked: assert property (wr_sel && !priv |=> $stable(sel_ff))
        else $error("select written without privilege");
    a_ro_ignored: assert property (hit(i_wr_stb, i_addr, A_STATUS) && !i_sample_stb
        |=> $stable(status_ff))
        else $error("status changed by host write");

    // ------------------------------------------------------------
    // Read path and data path checks
    // ------------------------------------------------------------
    // A read strobe is answered in the very next cycle, and only then.
    sequence s_read;
        i_rd_stb ##1 o_rd_valid;
    endsequence

    // Privileged low byte writes to the forced code words.
    sequence s_code0_lo_write;
        hit(i_wr_stb, i_addr, A_OVR_LO[OVR_CH0]) && priv;
    endsequence

    sequence s_code1_lo_write;
        hit(i_wr_stb, i_addr, A_OVR_LO[OVR_CH1]) && priv;
    endsequence

    a_read_answer: assert property (i_rd_stb |-> s_read)
        else $error("read not answered in the next cycle");
    a_read_quiet: assert property (!i_rd_stb |=> !o_rd_valid)
        else $error("read valid without a read");
    a_status_ok: assert property (o_rd_valid && rd_addr_ff == A_STATUS
        && $past(status_ff) == STATUS_OK |-> o_rdata == STATUS_OK)
        else $error("valid status read as non-zero");
    a_sel_reserved: assert property (o_rd_valid && rd_addr_ff == A_OVR_SEL
        |-> o_rdata[7:2] == 6'h00)
        else $error("reserved select bits read non-zero");
    a_temp_hi_live: assert property (o_rd_valid && rd_addr_ff == A_TEMP_HI
        |-> o_rdata[3:0] == $past(live_temp_ff[11:8]))
        else $error("temperature high nibble wrong");
    // While a sequence is open, the low bytes come from the frozen words.
    a_temp_lo_snap: assert property (o_rd_valid && rd_addr_ff == A_TEMP_LO
        && $past(pend_t_ff) |-> o_rdata == $past(snap_temp_ff[7:0]))
        else $error("temperature low not from snapshot");
    a_code0_lo_snap: assert property (o_rd_valid && rd_addr_ff == A_CH0_LO
        && $past(pend0_ff) |-> o_rdata == $past(snap0_ff[7:0]))
        else $error("code 0 low not from snapshot");
    a_code1_lo_snap: assert property (o_rd_valid && rd_addr_ff == A_CH1_LO
        && $past(pend1_ff) |-> o_rdata == $past(snap1_ff[7:0]))
        else $error("code 1 low not from snapshot");
    a_code1_mux: assert property (##1 o_dac1_code == ($past(sel_ff[SEL_CODE_BIT])
        ? $past(ovr_ff[OVR_CH1]) : $past(live1_ff)))
        else $error("dac 1 source wrong");
    a_index_live: assert property (!sel_ff[SEL_TEMP_BIT]
        |=> o_lut_index == $past(live_temp_ff))
        else $error("lut index not the sensor sample");
    // The low byte write takes the pending nibble along with it.
    a_lo_applies0: assert property (s_code0_lo_write
        |=> ovr_ff[OVR_CH0] == {$past(hold_hi_ff[OVR_CH0]), $past(i_wdata)})
        else $error("forced code 0 not applied by low byte");
    a_lo_applies1: assert property (s_code1_lo_write
        |=> ovr_ff[OVR_CH1] == {$past(hold_hi_ff[OVR_CH1]), $past(i_wdata)})
        else $error("forced code 1 not applied by low byte");
    a_code_ro: assert property (hit(i_wr_stb, i_addr, A_CH0_LO) && !i_lut_stb
        |=> $stable(live0_ff))
        else $error("code 0 changed by host write");
endmodule
`default_nettype wire

// *** sim/tdr_sensor_model.sv ***
// Behavioural sensor and LUT engine that feed the readout block.
`default_nettype none
module tdr_sensor_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic i_kick,
    input wire logic [11:0] i_temp,
    input wire logic [11:0] i_index,
    output logic o_sample_stb,
    output logic [11:0] o_sample,
    output logic o_ready,
    output logic o_lut_stb,
    output logic [11:0] o_code0,
    output logic [11:0] o_code1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dly_ff;
    // Outside a strobe the data lines toggle, so stale data never looks valid.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sample_stb <= 1'b0;
            o_sample <= 12'h000;
            o_ready <= 1'b0;
            o_lut_stb <= 1'b0;
            o_code0 <= 12'h000;
            o_code1 <= 12'h000;
            dly_ff <= 2'h0;
        end else begin
            o_sample_stb <= i_req | i_kick;
            o_sample <= (i_req | i_kick) ? i_temp : ~o_sample;
            o_ready <= o_ready | i_req;
            dly_ff <= {dly_ff[0], o_sample_stb};
            o_lut_stb <= dly_ff[1];
            o_code0 <= dly_ff[1] ? (i_index ^ 12'h5a5) : ~o_code0;
            o_code1 <= dly_ff[1] ? (i_index + 12'h123) : ~o_code1;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the temperature readout and override block.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tdr_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, kick = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [11:0] temp = 12'h000, w, smp, c0, c1, idx, d0, d1;
    logic rd_valid, req, s_stb, ready, l_stb;
    int n_fail = 0, checked = 0, cyc = 0, seed;
    always #5 clk = ~clk;
    tdr_readout #(.SAMPLE_CYC(20)) dut (.i_clk(clk), .i_rstn(rstn), .i_wr_stb(wr),
        .i_rd_stb(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rd_valid(rd_valid), .o_sample_req(req), .i_sample_stb(s_stb), .i_sample(smp),
        .i_sensor_ready(ready), .i_lut_stb(l_stb), .i_lut_code0(c0), .i_lut_code1(c1),
        .o_lut_index(idx), .o_dac0_code(d0), .o_dac1_code(d1));
    tdr_sensor_model sens (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_kick(kick),
        .i_temp(temp), .i_index(idx), .o_sample_stb(s_stb), .o_sample(smp),
        .o_ready(ready), .o_lut_stb(l_stb), .o_code0(c0), .o_code1(c1));
    // ------------------------------------------------------------
    // Expectations and host tasks
    // ------------------------------------------------------------
    function automatic logic [11:0] f0(input logic [11:0] t); return t ^ 12'h5a5; endfunction
    function automatic logic [11:0] f1(input logic [11:0] t); return t + 12'h123; endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk12(input string nm, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8("rd_valid", 8'h01, {7'h00, rd_valid});
        chk8($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // A new sample lands between the reads; the snapshot must hold the old one.
    task automatic coh(input bit skip);
        logic [11:0] t0;
        logic [11:0] e0;
        logic [11:0] e1;
        t0 = temp;
        e0 = f0(t0);
        e1 = f1(t0);
        rd_chk(A_TEMP_HI, {4'h0, t0[11:8]});
        @(posedge clk);
        temp <= 12'($urandom());
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        wait_cyc(8);
        if (!skip) rd_chk(A_TEMP_LO, t0[7:0]);
        rd_chk(A_CH0_HI, {4'h0, e0[11:8]});
        rd_chk(A_CH0_LO, e0[7:0]);
        rd_chk(A_CH1_HI, {4'h0, e1[11:8]});
        rd_chk(A_CH1_LO, e1[7:0]);
        wait_cyc(30);
        chk12("dac0", f0(temp), d0);
        chk12("dac1", f1(temp), d1);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(86);
        temp = 12'($urandom());
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(A_STATUS, STATUS_RST);
        rd_chk(A_OVR_SEL, 8'h00);
        wait_cyc(40);
        rd_chk(A_STATUS, STATUS_OK);
        wr_reg(A_STATUS, 8'h55);
        wr_reg(A_CH0_LO, 8'h55);
        rd_chk(A_STATUS, STATUS_OK);
        for (int i = 0; i < 6; i++) coh(i[0]);
        wr_reg(A_OVR_SEL, 8'h02);
        rd_chk(A_OVR_SEL, 8'h00);
        wr_reg(A_GATE, PWD_FIRST);
        wr_reg(A_GATE, PWD_PRIV);
        rd_chk(A_GATE, {6'h00, LVL_PRIV});
        wr_reg(A_OVR_SEL, 8'h02);
        rd_chk(A_OVR_SEL, 8'h02);
        wait_cyc(3);
        chk12("dac0", WORD_RST, d0);
        for (int c = OVR_CH0; c <= OVR_CH1; c++) begin
            w = 12'($urandom());
            wr_reg(A_OVR_HI[c], {4'h0, w[11:8]});
            wait_cyc(3);
            chk12("pending", WORD_RST, (c == OVR_CH0) ? d0 : d1);
            wr_reg(A_OVR_LO[c], w[7:0]);
            wait_cyc(3);
            chk12("forced", w, (c == OVR_CH0) ? d0 : d1);
        end
        rd_chk(A_OVR_HI[OVR_CH1], {4'h0, w[11:8]});
        rd_chk(A_OVR_LO[OVR_CH1], w[7:0]);
        wr_reg(A_OVR_SEL, 8'h01);
        w = 12'($urandom());
        wr_reg(A_OVR_HI[OVR_TEMP], {4'h0, w[11:8]});
        wr_reg(A_OVR_LO[OVR_TEMP], w[7:0]);
        wait_cyc(3);
        chk12("lut_index", w, idx);
        rd_chk(A_TEMP_HI, {4'h0, temp[11:8]});
        wait_cyc(30);
        chk12("dac0", f0(w), d0);
        wr_reg(A_OVR_SEL, 8'h00);
        wait_cyc(30);
        chk12("dac1", f1(temp), d1);
        finish_test();
    end
endmodule
`default_nettype wire
